// >>> design/hbgc_top.sv
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Operation
// RQ1: Gate-off input high drives all four gates low.
// RQ2: Low command high forces low gate on and high gate off.
// RQ3: Only high command turns high gate on; both low leave side off.
// RQ4: Undervoltage forces all four gates off regardless of other inputs.
// RQ5: Undervoltage clearing with gate-off low runs 400 ns refresh, lows on.
// RQ6: After refresh gates follow commands by the normal table.
// RQ7: Dead time delays turn-on only; turn-off passes immediately.
// RQ8: High setting governs low-to-high, low setting governs high-to-low.
// RQ9: Dead time counts from the turn-off edge of the other switch.
// RQ10: High gate held by latch set by on pulse, cleared by off pulse.
// RQ11: High-side on and off pulses are about 80 ns wide.
// RQ12: Two identical independent channels A and B.
// RQ13: Controller may tie high commands high and steer by low commands.
// RQ14: Dead times are cycle counts; never both gates of a side on.
// RQ15: Undervoltage overrides asynchronously and restarts refresh on each clearing.
module hbgc_top
    import hbgc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        global_gate_off,
    input  wire logic        undervoltage,
    input  wire logic        side_a_low_cmd,
    input  wire logic        side_a_high_cmd,
    input  wire logic        side_b_low_cmd,
    input  wire logic        side_b_high_cmd,
    output logic             side_a_low_gate,
    output logic             side_a_high_gate,
    output logic             side_b_low_gate,
    output logic             side_b_high_gate,
    output logic             side_a_high_on_pulse,
    output logic             side_a_high_off_pulse,
    output logic             side_b_high_on_pulse,
    output logic             side_b_high_off_pulse,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);

    typedef struct packed {
        logic [7:0]        sync;
        hbgc_cmd_s [1:0]   cmd;
        logic [1:0]        off_sync;
        hbgc_mode_e        mode;
        logic [REF_W-1:0]  refresh_cnt;
        hbgc_side_s [1:0]  side;
        logic [DT_W-1:0]   dt_high;
        logic [DT_W-1:0]   dt_low;
        logic              sw_off;
        logic              ack;
        logic [31:0]       rdata;
    } hbgc_state_s;

    hbgc_state_s st;
    hbgc_state_s next_st;

    logic       uv_sync1;
    logic       uv_sync2;
    logic [3:0] cmd_raw;

    assign cmd_raw = {side_b_low_cmd, side_b_high_cmd, side_a_low_cmd, side_a_high_cmd};

    // Undervoltage level synchroniser, reset by the level itself
    always_ff @(posedge sys_clk or negedge rst_n or posedge undervoltage) begin
        if (!rst_n || undervoltage) begin // [RQ15]
            uv_sync1 <= 1'b1;
            uv_sync2 <= 1'b1;
        end else begin
            uv_sync1 <= 1'b0;
            uv_sync2 <= uv_sync1;
        end
    end

    function automatic logic [DT_W-1:0] count_down(input logic [DT_W-1:0] v);
        count_down = (v == '0) ? v : v - 1'b1;
    endfunction : count_down

    function automatic logic [PUL_W-1:0] pulse_down(input logic [PUL_W-1:0] v);
        pulse_down = (v == '0) ? v : v - 1'b1;
    endfunction : pulse_down

    always_comb begin
        logic       gates_off;
        logic       want_low;
        logic       want_high;
        logic [7:0] reg_adr;
        next_st   = st;
        gates_off = 1'b0;
        want_low  = 1'b0;
        want_high = 1'b0;
        reg_adr   = wb_adr_i;

        // Input synchronisers, three stages for commands and two for gate-off
        next_st.sync     = {cmd_raw, st.sync[7:4]};
        next_st.cmd      = st.sync[3:0];
        next_st.off_sync = {global_gate_off, st.off_sync[1]};

        // Mode sequencing
        unique case (st.mode)
            HBGC_OFF: begin
                next_st.refresh_cnt = '0;
                if (!uv_sync2 && !st.off_sync[0] && !st.sw_off) begin // [RQ5]
                    next_st.mode        = HBGC_REFRESH;
                    next_st.refresh_cnt = REF_W'(REFRESH_CYCLES - 1);
                end
            end
            HBGC_REFRESH: begin
                next_st.refresh_cnt = st.refresh_cnt - 1'b1;
                if (st.refresh_cnt == '0) begin
                    next_st.mode = HBGC_RUN; // [RQ6]
                end
            end
            HBGC_RUN: begin
            end
            default: begin
                next_st.mode = HBGC_OFF;
            end
        endcase
        gates_off = uv_sync2 || st.off_sync[0] || st.sw_off; // [RQ1] [RQ4]
        if (gates_off) begin
            next_st.mode = (uv_sync2 || st.mode != HBGC_RUN) ? HBGC_OFF : HBGC_RUN; // [RQ15]
        end

        for (int i = 0; i < 2; i++) begin // [RQ12]
            next_st.side[i].on_pulse  = pulse_down(st.side[i].on_pulse);
            next_st.side[i].off_pulse = pulse_down(st.side[i].off_pulse);
            next_st.side[i].low_wait  = count_down(st.side[i].low_wait);
            next_st.side[i].high_wait = count_down(st.side[i].high_wait);
            if (gates_off || st.mode == HBGC_OFF) begin
                want_low  = 1'b0;
                want_high = 1'b0;
            end else if (st.mode == HBGC_REFRESH) begin
                want_low  = 1'b1; // [RQ5]
                want_high = 1'b0;
            end else begin
                want_low  = st.cmd[i].low_cmd; // [RQ2] [RQ13]
                want_high = !st.cmd[i].low_cmd && st.cmd[i].high_cmd; // [RQ3]
            end
            next_st.side[i].low_prev  = want_low;
            next_st.side[i].high_prev = want_high;

            // Turn-off is immediate, starts dead time for the partner
            if (!want_high && st.side[i].high_latch) begin // [RQ7]
                next_st.side[i].high_latch = 1'b0; // [RQ10]
                next_st.side[i].off_pulse  = PUL_W'(XLAT_PULSE_CYC); // [RQ11]
                next_st.side[i].low_wait   = st.dt_low; // [RQ8] [RQ9]
            end
            if (!want_low && st.side[i].low_gate) begin
                next_st.side[i].low_gate  = 1'b0; // [RQ7]
                next_st.side[i].high_wait = st.dt_high; // [RQ8] [RQ9]
            end

            // Turn-on only after dead time and with partner off
            if (want_high && !st.side[i].high_latch && !st.side[i].low_gate
                    && st.side[i].high_wait == '0 && !want_low) begin // [RQ14]
                next_st.side[i].high_latch = 1'b1; // [RQ10]
                next_st.side[i].on_pulse   = PUL_W'(XLAT_PULSE_CYC); // [RQ11]
            end
            if (want_low && !st.side[i].low_gate && !st.side[i].high_latch
                    && st.side[i].low_wait == '0) begin // [RQ14]
                next_st.side[i].low_gate = 1'b1;
            end
        end

        // Wishbone classic slave, one wait state
        next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
        if (wb_cyc_i && wb_stb_i && !st.ack) begin
            next_st.rdata = READ_UNMAP;
            unique case (reg_adr)
                ADDR_DEADTIME: begin
                    next_st.rdata[DT_HIGH_LSB +: DT_W] = st.dt_high;
                    next_st.rdata[DT_LOW_LSB +: DT_W]  = st.dt_low;
                    if (wb_we_i && wb_sel_i[0]) begin
                        next_st.dt_high = wb_dat_i[DT_HIGH_LSB +: DT_W]; // [RQ14]
                    end
                    if (wb_we_i && wb_sel_i[1]) begin
                        next_st.dt_low = wb_dat_i[DT_LOW_LSB +: DT_W]; // [RQ14]
                    end
                end
                ADDR_STATUS: begin
                    next_st.rdata[ST_REFRESH_BIT] = (st.mode == HBGC_REFRESH);
                    next_st.rdata[ST_UV_BIT]      = uv_sync2;
                    next_st.rdata[ST_OFF_BIT]     = st.off_sync[0];
                    next_st.rdata[ST_GATES_LSB +: 4] = {st.side[1].low_gate, st.side[1].high_latch,
                                                        st.side[0].low_gate, st.side[0].high_latch};
                end
                ADDR_CTRL: begin
                    next_st.rdata[CTRL_SWOFF_BIT] = st.sw_off;
                    if (wb_we_i && wb_sel_i[0]) begin
                        next_st.sw_off = wb_dat_i[CTRL_SWOFF_BIT];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st         <= '0;
            st.mode    <= HBGC_OFF;
            st.dt_high <= DT_HIGH_RST;
            st.dt_low  <= DT_LOW_RST;
        end else begin
            st <= next_st;
        end
    end

    // Gate outputs, forced off at once by the raw undervoltage level
    assign side_a_high_gate      = st.side[0].high_latch && !undervoltage; // [RQ4] [RQ15]
    assign side_a_low_gate       = st.side[0].low_gate && !undervoltage;
    assign side_b_high_gate      = st.side[1].high_latch && !undervoltage;
    assign side_b_low_gate       = st.side[1].low_gate && !undervoltage;
    assign side_a_high_on_pulse  = st.side[0].on_pulse != '0;
    assign side_a_high_off_pulse = st.side[0].off_pulse != '0;
    assign side_b_high_on_pulse  = st.side[1].on_pulse != '0;
    assign side_b_high_off_pulse = st.side[1].off_pulse != '0;
    assign wb_ack_o              = st.ack;
    assign wb_dat_o              = st.rdata;

endmodule : hbgc_top

`default_nettype wire

// >>> design/hbgc_pkg.sv
package hbgc_pkg;

    // Timing figures and derived cycle counts
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned REFRESH_NS       = 400;
    localparam int unsigned REFRESH_CYCLES   = (REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned XLAT_PULSE_NS    = 80;
    localparam int unsigned XLAT_PULSE_CYC   = (XLAT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Widths
    localparam int unsigned DT_W             = 8;
    localparam int unsigned REF_W            = 6;
    localparam int unsigned PUL_W            = 4;

    // Register map
    localparam logic [7:0] ADDR_DEADTIME     = 8'h00;
    localparam logic [7:0] ADDR_STATUS       = 8'h04;
    localparam logic [7:0] ADDR_CTRL         = 8'h08;

    // Field positions
    localparam int unsigned DT_HIGH_LSB      = 0;
    localparam int unsigned DT_LOW_LSB       = 8;
    localparam int unsigned ST_REFRESH_BIT   = 0;
    localparam int unsigned ST_UV_BIT        = 1;
    localparam int unsigned ST_OFF_BIT       = 2;
    localparam int unsigned ST_GATES_LSB     = 4;
    localparam int unsigned CTRL_SWOFF_BIT   = 0;

    // Reset values and the unmapped read value
    localparam logic [DT_W-1:0] DT_HIGH_RST  = 8'h0a;
    localparam logic [DT_W-1:0] DT_LOW_RST   = 8'h0a;
    localparam logic [31:0]     READ_UNMAP   = 32'h0000_0000;

    typedef enum logic [1:0] {
        HBGC_OFF,
        HBGC_REFRESH,
        HBGC_RUN
    } hbgc_mode_e;

    typedef struct packed {
        logic low_cmd;
        logic high_cmd;
    } hbgc_cmd_s;

    typedef struct packed {
        logic            low_gate;
        logic            high_latch;
        logic            low_prev;
        logic            high_prev;
        logic [DT_W-1:0] low_wait;
        logic [DT_W-1:0] high_wait;
        logic [PUL_W-1:0] on_pulse;
        logic [PUL_W-1:0] off_pulse;
    } hbgc_side_s;

endpackage : hbgc_pkg

// >>> verif/hbgc_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
// Controller beside the bridge inputs; registers the wanted commands
module hbgc_ctrl_model
    import hbgc_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire logic      rst_n,
    input  wire logic      tie_high,
    input  wire hbgc_cmd_s want_a,
    input  wire hbgc_cmd_s want_b,
    output hbgc_cmd_s      cmd_a,
    output hbgc_cmd_s      cmd_b
);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_a <= '0;
            cmd_b <= '0;
        end else begin
            cmd_a <= '{low_cmd: want_a.low_cmd, high_cmd: want_a.high_cmd | tie_high};
            cmd_b <= '{low_cmd: want_b.low_cmd, high_cmd: want_b.high_cmd | tie_high};
        end
    end
endmodule : hbgc_ctrl_model
`default_nettype wire

// >>> verif/hbgc_top_props.sv
`timescale 1ns/100ps
`default_nettype none
module hbgc_top_props
    import hbgc_pkg::*;
(
    input wire logic        sys_clk, rst_n, global_gate_off, undervoltage,
    input wire logic        side_a_low_cmd, side_a_high_cmd, side_b_low_cmd, side_b_high_cmd,
    input wire logic        side_a_low_gate, side_a_high_gate, side_b_low_gate, side_b_high_gate,
    input wire logic        side_a_high_on_pulse, side_a_high_off_pulse, side_b_high_on_pulse,
    input wire logic        side_b_high_off_pulse, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i, wb_dat_o,
    input wire logic [3:0]  wb_sel_i
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    gate_off_all_a: assert property (global_gate_off [*5] |-> !(side_a_low_gate | side_a_high_gate | side_b_low_gate | side_b_high_gate)) else $error("gates on while gate-off held");
    uv_all_off_a: assert property (undervoltage |-> !(side_a_low_gate | side_a_high_gate | side_b_low_gate | side_b_high_gate)) else $error("gates on during undervoltage");
    no_shoot_a: assert property (!(side_a_low_gate && side_a_high_gate) && !(side_b_low_gate && side_b_high_gate)) else $error("both gates of a side on");
    a_low_dom_a: assert property (side_a_low_cmd [*5] |-> !side_a_high_gate) else $error("side a high on under low command");
    b_low_dom_a: assert property (side_b_low_cmd [*5] |-> !side_b_high_gate) else $error("side b high on under low command");
    fast_off_a: assert property (!side_a_high_cmd [*5] |-> !side_a_high_gate) else $error("high turn-off delayed");
    dead_gap_a: assert property ($fell(side_a_low_gate) |-> !side_a_high_gate [*8]) else $error("high on inside dead time");
    pulse_wide_a: assert property ($rose(side_a_high_on_pulse) |-> side_a_high_on_pulse [*8] ##1 !side_a_high_on_pulse) else $error("on pulse not 8 cycles");
    latch_set_a: assert property ($rose(side_a_high_gate) |-> side_a_high_on_pulse || $past(side_a_high_on_pulse)) else $error("high gate set without on pulse");
    bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle after request");
endmodule : hbgc_top_props
bind hbgc_top hbgc_top_props props_u (.*);
`default_nettype wire

// >>> verif/tb_hbgc_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_hbgc_top
    import hbgc_pkg::*;
;
    logic        sys_clk = 0, rst_n = 0, global_gate_off = 0, undervoltage = 0, tie_high = 0;
    logic        cyc = 0, stb = 0, we = 0, a_lo, a_hi, b_lo, b_hi, ack;
    logic [7:0]  adr = '0;
    logic [31:0] wdat = '0, rdat, dat_o;
    hbgc_cmd_s   want_a = '0, want_b = '0, cmd_a, cmd_b;
    int          miscompares = 0, n_compared = 0, n;
    wire  [3:0]  g = {b_hi, b_lo, a_hi, a_lo};
    always #5 sys_clk = ~sys_clk;
    hbgc_ctrl_model ctrl_u (.sys_clk(sys_clk), .rst_n(rst_n), .tie_high(tie_high), .want_a(want_a),
        .want_b(want_b), .cmd_a(cmd_a), .cmd_b(cmd_b));
    hbgc_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .global_gate_off(global_gate_off),
        .undervoltage(undervoltage), .side_a_low_cmd(cmd_a.low_cmd), .side_a_high_cmd(cmd_a.high_cmd),
        .side_b_low_cmd(cmd_b.low_cmd), .side_b_high_cmd(cmd_b.high_cmd), .side_a_low_gate(a_lo),
        .side_a_high_gate(a_hi), .side_b_low_gate(b_lo), .side_b_high_gate(b_hi), .side_a_high_on_pulse(),
        .side_a_high_off_pulse(), .side_b_high_on_pulse(), .side_b_high_off_pulse(), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(dat_o),
        .wb_ack_o(ack));
    task give_verdict;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, s);
            miscompares++;
        end
    endtask : chk
    task wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sys_clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        do begin
            @(posedge sys_clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        rdat = dat_o;
        cyc <= 0; stb <= 0;
        if (k >= 50) begin
            miscompares++;
            give_verdict;
        end
    endtask : wb_xfer
    task wait_gate(input int i, input logic v, output int c);
        c = 0;
        do begin
            @(posedge sys_clk);
            c++;
        end while (g[i] !== v && c < 300);
        if (c >= 300) begin
            miscompares++;
            give_verdict;
        end
    endtask : wait_gate
    task t_refresh;
        @(posedge sys_clk); undervoltage <= 1;
        #1 chk("uv gates", 0, g);
        repeat (3) @(posedge sys_clk); undervoltage <= 0;
        repeat (10) @(posedge sys_clk); chk("refresh gates", 4'b0101, g);
        repeat (50) @(posedge sys_clk); chk("after refresh", 0, g);
        $display("test refresh done");
    endtask : t_refresh
    task t_table;
        for (int i = 0; i < 4; i++) begin
            want_a <= i[1:0]; want_b <= ~i[1:0];
            repeat (40) @(posedge sys_clk);
            chk("table gates", {i[1] & ~i[0], ~i[1], ~i[1] & i[0], i[1]}, g);
        end
        $display("test table done");
    endtask : t_table
    task t_dead;
        wb_xfer(1, ADDR_DEADTIME, 32'h0000_0c14);
        wb_xfer(0, ADDR_DEADTIME, 0); chk("dead time reg", 32'h0000_0c14, rdat);
        wb_xfer(0, 8'hfc, 0); chk("unmapped read", READ_UNMAP, rdat);
        want_a <= 2'b10; repeat (40) @(posedge sys_clk);
        want_a <= 2'b01; wait_gate(0, 0, n); wait_gate(1, 1, n);
        chk("low to high gap", 21, n);
        want_a <= 2'b10; wait_gate(1, 0, n); wait_gate(0, 1, n);
        chk("high to low gap", 13, n);
        $display("test dead time done");
    endtask : t_dead
    task t_off;
        want_a <= 2'b01; global_gate_off <= 1;
        repeat (8) @(posedge sys_clk); chk("gate off", 0, g);
        global_gate_off <= 0; want_b <= 0; repeat (70) @(posedge sys_clk);
        chk("side a high", 4'b0010, g);
        undervoltage <= 1;
        #1 chk("uv at once", 0, g);
        @(posedge sys_clk); undervoltage <= 0;
        repeat (20) @(posedge sys_clk); chk("refresh again", 4'b0101, g);
        $display("test gate off done");
    endtask : t_off
    task t_tie;
        tie_high <= 1; want_a <= 2'b10; want_b <= 0;
        repeat (80) @(posedge sys_clk); chk("tied highs", 4'b1001, g);
        wb_xfer(0, ADDR_STATUS, 0); chk("status reg", 32'h0000_0060, rdat);
        wb_xfer(1, ADDR_CTRL, 32'h0000_0001);
        repeat (5) @(posedge sys_clk); chk("soft off gates", 0, g);
        wb_xfer(0, ADDR_CTRL, 0); chk("ctrl reg", 32'h0000_0001, rdat);
        wb_xfer(1, ADDR_CTRL, 0);
        $display("test tied high done");
    endtask : t_tie
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1;
        repeat (60) @(posedge sys_clk);
        t_refresh;
        t_table;
        t_dead;
        t_off;
        t_tie;
        give_verdict;
    end
endmodule : tb_hbgc_top
`default_nettype wire
